// ===== shared/spi_core_pkg.sv
// Constants and types shared by the serial port core
package spi_core_pkg;

  // Data width of the shift register and buffers
  localparam int DATA_W = 8;

  // Control register field positions
  localparam int CTL_RATE_LSB = 0; // Three-bit clock rate field
  localparam int CTL_CLOCK_PHASE_BIT = 3;
  localparam int CTL_CLOCK_POLARITY_BIT = 4;
  localparam int CTL_MASTER = 5;
  localparam int CTL_PORT_EN = 6;
  localparam int CTL_IRQ_EN = 7;

  // Control/status register field positions
  localparam int ST_SOFT_LEVEL = 0;
  localparam int ST_SOFT_MANAGE = 1;
  localparam int ST_MODE_FAULT_FLAG = 4;
  localparam int ST_OVR = 5;
  localparam int ST_WRITE_COLLISION_FLAG = 6;
  localparam int ST_DONE = 7;

  // Reset values
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Clock edges in one byte and index of the last one
  localparam logic [3:0] EDGE_LAST = 4'hF;

  // System clock cycles per half period of the master clock, per rate code
  // Divisors 4, 8, 16, 32, 64, 128; codes 6 and 7 repeat the slowest
  localparam logic [6:0] RATE_HALF [0:7] = '{
    7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h40, 7'h40
  };

  // Number of synchronised pin inputs
  localparam int PIN_N = 4;

  // Master shifter states
  typedef enum logic {XF_IDLE, XF_RUN} xfer_state_e;

endpackage : spi_core_pkg

// ===== rtl/pin_sync.sv
// Two-flop synchronisers for the serial pin inputs
`timescale 1ns/1ps
module pin_sync (
  input wire logic sys_clk, // System clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic [spi_core_pkg::PIN_N-1:0] pin_in, // Raw pin levels
  output logic [spi_core_pkg::PIN_N-1:0] pin_out // Synchronised levels
);
  import spi_core_pkg::*;

  logic [PIN_N-1:0] meta_q;

  // One pair of flops per pin; only the second flop is read outside
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi = gi + 1) begin : g_pin
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          meta_q[gi] <= 1'b0;
          pin_out[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= pin_in[gi];
          pin_out[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

endmodule : pin_sync

// ===== rtl/spi_core.sv
// Byte-wide serial port core, master or slave, with flag sequences
`timescale 1ns/1ps
// Functional notes
// [RULE1] Master data write loads eight-bit shifter, sent on MOSI MSB first.
// [RULE2] Master drives SCK at six rates, fastest clock over four, set polarity.
// [RULE3] External master must clock SCK no faster than clock over two.
// [RULE4] Master starts every transfer; slave returns MISO on the same clock.
// [RULE5] Single-wire use joins MISO and MOSI; only one direction at once.
// [RULE6] Master and slave use identical polarity and phase settings.
// [RULE7] Soft-manage set: internal select follows soft level, pin ignored.
// [RULE8] As master, internal select must stay high all the time.
// [RULE9] Phase one slave: select held low for the whole transmission.
// [RULE10] Phase zero slave: select high between bytes, else write collision.
// [RULE11] Master setup: rate, polarity, phase, then select, then enable.
// [RULE12] Master and enable bits stay set only while select is high.
// [RULE13] Master bit ignored if status register not written before control.
// [RULE14] Byte end sets done flag; interrupt if enabled and CPU unmasked.
// [RULE15] Master: done clears by status access then data read.
// [RULE16] Slave: done clears by status access then data read or write.
// [RULE17] While done is set, data writes ignored until status is read.
// [RULE18] Slave data write loads shifter, sent on MISO MSB first.
// [RULE19] Slave transfer begins with master clock and MSB on MOSI.
// [RULE20] Slave setup: polarity, phase, select, clear master, set enable.
// [RULE21] Done must be cleared before the next byte ends, else overrun.
// [RULE22] Select low as master: mode fault, drop enable and master.
// [RULE23] Write during transfer discarded, transfer goes on, collision flag.
// [RULE24] Byte end while done set raises overrun; status read clears it.
// [RULE25] Idle level equals polarity; phase picks first or second edge.
// [RULE26] Reset clears flags, enable, master and leaves shifter idle.
module spi_core (
  input wire logic sys_clk, // System clock, 200 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic ctrl_wr, // Control register write strobe
  input wire logic [7:0] ctrl_wdata, // Control register write data
  output logic [7:0] ctrl_rdata, // Control register read value
  input wire logic csr_wr, // Control/status write strobe
  input wire logic csr_rd, // Control/status read strobe
  input wire logic [7:0] csr_wdata, // Control/status write data
  output logic [7:0] csr_rdata, // Control/status read value
  input wire logic data_wr, // Data register write strobe
  input wire logic data_rd, // Data register read strobe
  input wire logic [7:0] data_wdata, // Data register write data
  output logic [7:0] data_rdata, // Received byte buffer
  input wire logic irq_mask, // CPU interrupt mask, high masks
  output logic irq_req, // Interrupt request, active high
  input wire logic sck_in, // Serial clock pin level
  output logic sck_out, // Serial clock drive value
  output logic sck_oe_n, // Serial clock drive enable, active low
  input wire logic mosi_in, // MOSI pin level
  output logic mosi_out, // MOSI drive value
  output logic mosi_oe_n, // MOSI drive enable, active low
  input wire logic miso_in, // MISO pin level
  output logic miso_out, // MISO drive value
  output logic miso_oe_n, // MISO drive enable, active low
  input wire logic ss_n_in // Slave select pin, active low
);
  import spi_core_pkg::*;

  // Configuration and flag registers
  logic irq_en_q, port_en_q, master_q, clock_polarity_bit_q, clock_phase_bit_q;
  logic [2:0] rate_q;
  logic soft_manage_q, soft_level_q, csr_written_q;
  logic done_q, write_collision_flag_q, ovr_q, mode_fault_flag_q;
  logic done_seq_q, csr_rd_seen_q, write_collision_flag_seq_q, mode_fault_flag_seq_q;
  // Shifter state
  xfer_state_e state_q;
  logic [6:0] div_cnt_q;
  logic [3:0] edge_cnt_q;
  logic [DATA_W-1:0] shift_q, rx_buf_q;
  logic out_bit_q, sck_q, sck_prev_q, irq_q;
  logic sck_oe_n_q, mosi_oe_n_q, miso_oe_n_q;
  logic [PIN_N-1:0] pins_s;
  logic sck_s, mosi_s, miso_s, ss_n_s;

  // Pin inputs pass two flops before any logic reads them
  pin_sync u_pin_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin_in({sck_in, mosi_in, miso_in, ss_n_in}),
    .pin_out(pins_s)
  );
  assign {sck_s, mosi_s, miso_s, ss_n_s} = pins_s;

  // Internal select and mode decode
  logic ss_int, mode_fault, master_run, slave_sel, busy;
  assign ss_int = soft_manage_q ? soft_level_q : ss_n_s; // [RULE7]
  // Select low while mastering is a fault, drop the mode bits [RULE8]
  assign mode_fault = port_en_q & master_q & ~ss_int; // [RULE22] [RULE12]
  assign master_run = (state_q == XF_RUN);
  assign slave_sel = port_en_q & ~master_q & ~ss_int;
  // Phase zero slave is busy for as long as select stays low [RULE10]
  assign busy = master_run
              | (slave_sel & (~clock_phase_bit_q | (edge_cnt_q != 4'h0))); // [RULE23]

  // Data write qualification
  logic wr_inhibit, wr_accept, collide, start;
  assign wr_inhibit = done_q & ~csr_rd_seen_q; // [RULE17]
  assign wr_accept = data_wr & ~wr_inhibit & ~busy;
  assign collide = data_wr & ~wr_inhibit & busy; // [RULE23]
  assign start = wr_accept & port_en_q & master_q & ~mode_fault; // [RULE1]

  // Edge generation: master divider tick or synchronised slave edge
  logic [6:0] half_m1;
  logic div_tick, sck_edge_s, edge_fire, sample_edge, drive_edge;
  logic byte_done, rx_bit;
  logic [DATA_W-1:0] shift_in;
  assign half_m1 = RATE_HALF[rate_q] - 7'h01; // [RULE2]
  assign div_tick = master_run & (div_cnt_q == half_m1);
  // Sync delay limits slave clock to half the system clock [RULE3]
  assign sck_edge_s = slave_sel & (sck_s ^ sck_prev_q); // [RULE19]
  assign edge_fire = div_tick | sck_edge_s;
  // Even edges lead; phase zero samples them, phase one the trailing
  assign sample_edge = edge_fire & (edge_cnt_q[0] == clock_phase_bit_q); // [RULE25]
  assign drive_edge = edge_fire & ~sample_edge; // [RULE6]
  assign byte_done = edge_fire & (edge_cnt_q == EDGE_LAST);
  // Master listens on MISO, slave on MOSI, both on the master clock
  assign rx_bit = master_q ? miso_s : mosi_s; // [RULE4]
  assign shift_in = {shift_q[DATA_W-2:0], rx_bit};

  // Register access decode
  logic done_clear, write_collision_flag_clear, mode_fault_flag_clear, set_ok;
  // Slave may finish the sequence with a write too [RULE16]
  assign done_clear = done_seq_q
                    & (data_rd | (data_wr & ~master_q)); // [RULE15]
  assign write_collision_flag_clear = write_collision_flag_seq_q & data_rd;
  assign mode_fault_flag_clear = mode_fault_flag_seq_q & ctrl_wr;
  // Mode bits cannot be set during a fault except in its clear sequence
  assign set_ok = ~mode_fault_flag_q | mode_fault_flag_seq_q;

  // Control register; a fault overrides a same-cycle write [RULE26]
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      {irq_en_q, port_en_q, master_q, clock_polarity_bit_q, clock_phase_bit_q} <= 5'h00;
      rate_q <= CTL_RESET[CTL_RATE_LSB +: 3];
    end else if (mode_fault) begin
      port_en_q <= 1'b0; // [RULE22]
      master_q <= 1'b0;
    end else if (ctrl_wr) begin
      // Setup order is software's job; an early master bit is dropped
      irq_en_q <= ctrl_wdata[CTL_IRQ_EN]; // [RULE11] [RULE20]
      port_en_q <= ctrl_wdata[CTL_PORT_EN] & set_ok;
      master_q <= ctrl_wdata[CTL_MASTER] & set_ok & csr_written_q; // [RULE13]
      clock_polarity_bit_q <= ctrl_wdata[CTL_CLOCK_POLARITY_BIT]; // [RULE6]
      clock_phase_bit_q <= ctrl_wdata[CTL_CLOCK_PHASE_BIT];
      rate_q <= ctrl_wdata[CTL_RATE_LSB +: 3];
    end
  end

  // Software select controls
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      soft_manage_q <= CSR_RESET[ST_SOFT_MANAGE];
      soft_level_q <= CSR_RESET[ST_SOFT_LEVEL];
      csr_written_q <= 1'b0;
    end else if (csr_wr) begin
      soft_manage_q <= csr_wdata[ST_SOFT_MANAGE]; // [RULE7]
      soft_level_q <= csr_wdata[ST_SOFT_LEVEL];
      csr_written_q <= 1'b1;
    end
  end

  // Status flags; a hardware set always wins over a software clear
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      {done_q, write_collision_flag_q, ovr_q, mode_fault_flag_q} <= 4'h0; // [RULE26]
    end else begin
      done_q <= byte_done | (done_q & ~done_clear); // [RULE14]
      write_collision_flag_q <= collide | (write_collision_flag_q & ~write_collision_flag_clear); // [RULE23]
      // A late clear by software shows up as overrun [RULE21]
      ovr_q <= (byte_done & done_q) | (ovr_q & ~csr_rd); // [RULE24]
      mode_fault_flag_q <= mode_fault | (mode_fault_flag_q & ~mode_fault_flag_clear); // [RULE22]
    end
  end

  // Clearing sequence trackers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      {done_seq_q, csr_rd_seen_q, write_collision_flag_seq_q, mode_fault_flag_seq_q} <= 4'h0;
    end else begin
      done_seq_q <= (done_seq_q | ((csr_rd | csr_wr) & done_q))
                  & ~done_clear; // [RULE15] [RULE16]
      csr_rd_seen_q <= (csr_rd_seen_q | (csr_rd & done_q))
                     & ~done_clear; // [RULE17]
      write_collision_flag_seq_q <= (write_collision_flag_seq_q | (csr_rd & write_collision_flag_q)) & ~write_collision_flag_clear;
      mode_fault_flag_seq_q <= (mode_fault_flag_seq_q | (csr_rd & mode_fault_flag_q)) & ~mode_fault_flag_clear;
    end
  end

  // Master sequencer; a mode fault aborts the byte
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= XF_IDLE; // [RULE26]
    end else begin
      case (state_q)
        XF_IDLE: if (start) state_q <= XF_RUN;
        XF_RUN: if (byte_done | mode_fault) state_q <= XF_IDLE;
        default: state_q <= XF_IDLE;
      endcase
    end
  end

  // Divider runs only during a master byte and is held at zero otherwise
  always_ff @(posedge sys_clk) begin
    if (reset || start || div_tick || !master_run) begin
      div_cnt_q <= 7'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 7'h01;
    end
  end

  // Select high frames each slave byte, so the count restarts [RULE9]
  always_ff @(posedge sys_clk) begin
    if (reset || start || (!master_run && !slave_sel)) begin
      edge_cnt_q <= 4'h0;
    end else if (edge_fire) begin
      edge_cnt_q <= edge_cnt_q + 4'h1; // Wraps to zero after the last
    end
  end

  // Shifter, load on accepted write; slave load drives MISO [RULE18]
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      shift_q <= DATA_RESET;
      out_bit_q <= 1'b0;
    end else if (wr_accept) begin
      shift_q <= data_wdata; // [RULE1]
      out_bit_q <= data_wdata[DATA_W-1];
    end else begin
      if (sample_edge) shift_q <= shift_in;
      if (drive_edge) out_bit_q <= shift_q[DATA_W-1];
    end
  end

  // Receive buffer keeps the first byte after the flag was cleared
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_buf_q <= DATA_RESET;
    end else if (byte_done && !done_q) begin
      rx_buf_q <= sample_edge ? shift_in : shift_q; // [RULE24]
    end
  end

  // Serial clock idles at the polarity level [RULE25]
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sck_q <= 1'b0;
      sck_prev_q <= 1'b0;
    end else begin
      sck_q <= master_run ? (sck_q ^ div_tick) : clock_polarity_bit_q; // [RULE2]
      sck_prev_q <= sck_s;
    end
  end

  // Pin enables, registered; MISO driven only by a selected slave
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      {sck_oe_n_q, mosi_oe_n_q, miso_oe_n_q} <= 3'h7;
    end else begin
      sck_oe_n_q <= ~(port_en_q & master_q);
      mosi_oe_n_q <= ~(port_en_q & master_q);
      miso_oe_n_q <= ~slave_sel; // [RULE5]
    end
  end

  // Interrupt for done, mode fault and overrun; collision never raises it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_en_q & ~irq_mask & (done_q | mode_fault_flag_q | ovr_q); // [RULE14]
    end
  end

  // Outputs straight from flops
  assign ctrl_rdata = {irq_en_q, port_en_q, master_q, clock_polarity_bit_q, clock_phase_bit_q, rate_q};
  assign csr_rdata = {done_q, write_collision_flag_q, ovr_q, mode_fault_flag_q, 2'b00,
                      soft_manage_q, soft_level_q};
  assign data_rdata = rx_buf_q;
  assign irq_req = irq_q;
  assign sck_out = sck_q;
  assign sck_oe_n = sck_oe_n_q;
  assign mosi_out = out_bit_q;
  assign mosi_oe_n = mosi_oe_n_q;
  assign miso_out = out_bit_q;
  assign miso_oe_n = miso_oe_n_q;

  // Checks on the design's own behaviour
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_arm;
    csr_rd && done_q && !byte_done;
  endsequence
  sequence s_drain;
    data_rd && !byte_done;
  endsequence

  AST_START_LOADS: assert property ( // [RULE1]
    start |=> master_run && shift_q == $past(data_wdata)
              && out_bit_q == $past(data_wdata[DATA_W-1]))
    else $error("start did not load shifter");
  AST_FAST_EDGE: assert property ( // [RULE2]
    (start && rate_q == 3'h0) |-> ##3 (sck_q != $past(sck_q)))
    else $error("fastest rate first edge late");
  AST_BYTE_TIME: assert property ( // [RULE14]
    (start && rate_q == 3'h0) |-> ##33 (done_q || mode_fault_flag_q))
    else $error("master byte did not complete in 32 cycles");
  AST_IDLE_LEVEL: assert property ( // [RULE25]
    ($past(state_q) == XF_IDLE && !master_run) |-> sck_q == $past(clock_polarity_bit_q))
    else $error("idle clock not at polarity");
  AST_MODE_FAULT: assert property ( // [RULE22]
    mode_fault |=> mode_fault_flag_q && !port_en_q && !master_q)
    else $error("mode fault not handled");
  AST_COLLIDE: assert property ( // [RULE23]
    (collide && master_run && !byte_done) |=> write_collision_flag_q && master_run)
    else $error("collision disturbed transfer");
  AST_INHIBIT: assert property ( // [RULE17]
    (data_wr && wr_inhibit && !edge_fire) |=> $stable(shift_q)
      && (!write_collision_flag_q || $past(write_collision_flag_q)))
    else $error("write accepted while done set");
  AST_OVERRUN: assert property ( // [RULE24]
    (byte_done && done_q) |=> ovr_q && $stable(rx_buf_q))
    else $error("overrun not flagged");
  AST_DONE_SEQ: assert property ( // [RULE15]
    (s_arm ##[1:4] s_drain) |=> !done_q)
    else $error("done not cleared by sequence");
  AST_DONE_HOLD: assert property ( // [RULE16]
    (done_q && !done_seq_q && !csr_rd && !csr_wr) |=> done_q)
    else $error("done cleared without status access");
  AST_IRQ: assert property ( // [RULE14]
    (done_q && irq_en_q && !irq_mask) |=> irq_req)
    else $error("interrupt not raised");
  AST_MASTER_GATE: assert property ( // [RULE13]
    (ctrl_wr && !csr_written_q && !master_q) |=> !master_q)
    else $error("master set before status write");

endmodule : spi_core

// ===== bench/serial_peer.sv
// Behavioural far-side serial device, slave by default, master on request
`timescale 1ns/1ps
module serial_peer (
  input wire logic sck_w, // Serial clock wire level
  input wire logic mosi_w, // MOSI wire level
  input wire logic miso_w, // MISO wire level
  input wire logic clock_polarity_bit, // Clock polarity shared with the core
  input wire logic clock_phase_bit, // Clock phase shared with the core
  output logic p_sck, // Clock drive, idles at polarity when released
  output logic p_mosi, // MOSI drive while acting as master
  output logic p_miso, // MISO drive while acting as slave
  output logic p_ss_n // Slave select drive, active low
);
  localparam time HALF = 40ns; // Eight system cycles, far below clock/2
  logic [7:0] sh;
  logic [7:0] rx;
  logic master_q;
  int edges;

  initial begin
    {master_q, p_mosi, p_miso, sh, rx} = 19'h00000;
    p_sck = 1'b0;
    p_ss_n = 1'b1;
    edges = 0;
  end

  // Released clock line is pulled to the idle level
  always @(clock_polarity_bit) if (!master_q) p_sck = clock_polarity_bit;

  // Preload the reply; phase zero needs the MSB before the first edge
  task automatic load(input logic [7:0] d);
    sh = d;
    p_miso = d[7];
  endtask : load

  // Slave role: sample on the capture edge, shift on the other one
  always @(sck_w) if (!master_q) begin
    if ((sck_w != clock_polarity_bit) ^ clock_phase_bit) begin
      rx = {rx[6:0], mosi_w};
      edges++;
    end else if (clock_phase_bit) begin
      p_miso = sh[7];
      sh = sh << 1;
    end else begin
      sh = sh << 1;
      p_miso = sh[7];
    end
  end

  // Master role: select held low over the byte, raised after it
  task automatic xfer(input logic [7:0] d);
    master_q = 1'b1;
    p_ss_n = 1'b0;
    p_sck = clock_polarity_bit;
    #(HALF);
    for (int i = 7; i >= 0; i--) begin
      if (clock_phase_bit) p_sck = !clock_polarity_bit;
      p_mosi = d[i];
      #(HALF);
      p_sck = clock_phase_bit ? clock_polarity_bit : !clock_polarity_bit;
      rx = {rx[6:0], miso_w};
      #(HALF);
      if (!clock_phase_bit) p_sck = clock_polarity_bit;
    end
    // Hold select past the last edge so the core sees it while selected
    #(HALF);
    p_ss_n = 1'b1;
    p_mosi = !p_mosi; // Released line must not keep the last bit
    master_q = 1'b0;
  endtask : xfer
endmodule : serial_peer

// ===== bench/test_spi_master_slave_core.sv
// Self-checking testbench for the serial port core
`timescale 1ns/1ps
module test_spi_master_slave_core;
  import spi_core_pkg::*;
  logic sys_clk = 1'b0, reset = 1'b1, irq_mask = 1'b0, tb_ss_n = 1'b1;
  logic ctrl_wr = 1'b0, csr_wr = 1'b0, csr_rd = 1'b0;
  logic data_wr = 1'b0, data_rd = 1'b0, clock_polarity_bit = 1'b0, clock_phase_bit = 1'b0;
  logic [7:0] ctrl_wdata = 8'h00, csr_wdata = 8'h00, data_wdata = 8'h00;
  logic [7:0] ctrl_rdata, csr_rdata, data_rdata;
  logic irq_req, sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
  logic p_sck, p_mosi, p_miso, p_ss_n, sck_last = 1'b0;
  wire logic sck_w, mosi_w, miso_w;
  int miscompares = 0, num_checks = 0, cyc = 0, last_t = 0, gap = 0, n;

  always #2.5 sys_clk = ~sys_clk;

  // Wire levels resolved from the core's enables; the peer drives otherwise
  assign sck_w = !sck_oe_n ? sck_out : p_sck;
  assign mosi_w = !mosi_oe_n ? mosi_out : p_mosi;
  assign miso_w = !miso_oe_n ? miso_out : p_miso;

  spi_core u_dut (.sys_clk(sys_clk), .reset(reset), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata), .csr_wr(csr_wr),
    .csr_rd(csr_rd), .csr_wdata(csr_wdata), .csr_rdata(csr_rdata),
    .data_wr(data_wr), .data_rd(data_rd), .data_wdata(data_wdata),
    .data_rdata(data_rdata), .irq_mask(irq_mask), .irq_req(irq_req),
    .sck_in(sck_w), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
    .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n),
    .miso_in(miso_w), .miso_out(miso_out), .miso_oe_n(miso_oe_n),
    .ss_n_in(p_ss_n & tb_ss_n));

  serial_peer u_peer (.sck_w(sck_w), .mosi_w(mosi_w), .miso_w(miso_w),
    .clock_polarity_bit(clock_polarity_bit), .clock_phase_bit(clock_phase_bit), .p_sck(p_sck), .p_mosi(p_mosi),
    .p_miso(p_miso), .p_ss_n(p_ss_n));

  // Cycles between the last two master clock toggles give the half period
  always @(posedge sys_clk) begin
    cyc++;
    if (sck_out !== sck_last) begin
      gap = cyc - last_t;
      last_t = cyc;
    end
    sck_last = sck_out;
  end

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One strobe pulse: 0 ctrl write, 1 csr write, 2 data write, 3/4 reads
  task automatic acc(input int k, input logic [7:0] d);
    @(negedge sys_clk);
    ctrl_wdata = d;
    csr_wdata = d;
    data_wdata = d;
    case (k)
      0: ctrl_wr = 1'b1;
      1: csr_wr = 1'b1;
      2: data_wr = 1'b1;
      3: csr_rd = 1'b1;
      default: data_rd = 1'b1;
    endcase
    @(negedge sys_clk);
    {ctrl_wr, csr_wr, data_wr, csr_rd, data_rd} = 5'h00;
  endtask : acc

  function automatic logic [7:0] flag(input int b);
    return {7'h00, csr_rdata[b]};
  endfunction : flag

  // Bounded wait for the byte-complete flag
  task automatic wait_done;
    n = 0;
    while (csr_rdata[ST_DONE] !== 1'b1 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    chk("done", 8'h01, flag(ST_DONE));
  endtask : wait_done

  // Select written before the master bit, so the master bit is honoured
  task automatic setup_master(input logic [2:0] r, input logic pol, ph);
    clock_polarity_bit = pol;
    clock_phase_bit = ph;
    acc(0, {3'h0, pol, ph, r});
    acc(1, 8'h03);
    acc(0, {3'h7, pol, ph, r});
  endtask : setup_master

  task automatic t_reset;
    chk("ctrl", CTL_RESET, ctrl_rdata);
    chk("csr", CSR_RESET, csr_rdata);
    chk("rdata", DATA_RESET, data_rdata);
    chk("pins", 8'h1C, {3'h0, sck_oe_n, mosi_oe_n, miso_oe_n, irq_req,
        sck_out});
    // Master bit written before any status write must be dropped
    acc(0, 8'h60);
    chk("master gated", 8'h40, ctrl_rdata & 8'h60);
  endtask : t_reset

  // All four clock modes, full-duplex byte with the slave model
  task automatic t_master;
    for (int m = 0; m < 4; m++) begin
      setup_master(3'h1, m[1], m[0]);
      chk("sck idle", {7'h00, clock_polarity_bit}, {7'h00, sck_out});
      u_peer.load(8'h3C ^ m[7:0]);
      acc(2, 8'hA5 ^ m[7:0]);
      chk("miso free", 8'h01, {7'h00, miso_oe_n});
      wait_done();
      chk("rx byte", 8'h3C ^ m[7:0], data_rdata);
      chk("peer rx", 8'hA5 ^ m[7:0], u_peer.rx);
      // Interrupt request is registered one cycle behind the flag
      @(negedge sys_clk);
      chk("irq", 8'h01, {7'h00, irq_req});
      acc(3, 8'h00);
      acc(4, 8'h00);
      chk("done clr", 8'h00, flag(ST_DONE));
    end
  endtask : t_master

  // Inhibited write, collision, overrun, mask and clear sequences
  task automatic t_flags;
    setup_master(3'h1, 1'b0, 1'b0);
    u_peer.load(8'h81);
    acc(2, 8'h42);
    wait_done();
    n = u_peer.edges;
    acc(2, 8'h24);
    repeat (40) @(negedge sys_clk);
    chk("no start", n[7:0], u_peer.edges[7:0]);
    acc(3, 8'h00);
    chk("done held", 8'h01, flag(ST_DONE));
    acc(2, 8'h5A);
    acc(2, 8'h77);
    chk("write_collision_flag", 8'h01, flag(ST_WRITE_COLLISION_FLAG));
    repeat (100) @(negedge sys_clk);
    chk("ovr", 8'h01, flag(ST_OVR));
    chk("sent on", 8'h5A, u_peer.rx);
    chk("rx kept", 8'h81, data_rdata);
    irq_mask = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("masked", 8'h00, {7'h00, irq_req});
    irq_mask = 1'b0;
    acc(3, 8'h00);
    chk("ovr clr", 8'h00, flag(ST_OVR));
    acc(4, 8'h00);
    chk("flags clr", 8'h00, csr_rdata & 8'hF0);
  endtask : t_flags

  task automatic t_rates;
    for (int r = 0; r < 6; r++) begin
      setup_master(r[2:0], 1'b0, 1'b0);
      acc(2, 8'h00);
      wait_done();
      chk("half period", 8'h02 << r, gap[7:0]);
      acc(3, 8'h00);
      acc(4, 8'h00);
    end
  endtask : t_rates

  task automatic t_mode_fault_flag;
    setup_master(3'h1, 1'b0, 1'b0);
    tb_ss_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk("pin ignored", 8'h00, flag(ST_MODE_FAULT_FLAG));
    tb_ss_n = 1'b1;
    acc(1, 8'h02);
    repeat (4) @(negedge sys_clk);
    chk("mode_fault_flag", 8'h01, flag(ST_MODE_FAULT_FLAG));
    chk("ctrl drop", 8'h00, ctrl_rdata & 8'h60);
    chk("mode_fault_flag irq", 8'h01, {7'h00, irq_req});
    acc(1, 8'h03);
    acc(0, 8'hE1);
    chk("set refused", 8'h00, ctrl_rdata & 8'h60);
    acc(3, 8'h00);
    acc(0, 8'hE1);
    chk("mode_fault_flag clr", 8'h00, flag(ST_MODE_FAULT_FLAG));
    chk("ctrl back", 8'h60, ctrl_rdata & 8'h60);
  endtask : t_mode_fault_flag

  // Slave bytes in both phases, then a collision with select held low
  task automatic t_slave;
    for (int p = 0; p < 2; p++) begin
      clock_polarity_bit = 1'b0;
      clock_phase_bit = p[0];
      acc(1, 8'h00);
      acc(0, {4'h4, p[0], 3'h0});
      acc(2, 8'hC3 ^ p[7:0]);
      u_peer.xfer(8'h96 ^ p[7:0]);
      wait_done();
      chk("slave rx", 8'h96 ^ p[7:0], data_rdata);
      chk("slave tx", 8'hC3 ^ p[7:0], u_peer.rx);
      acc(3, 8'h00);
      acc(2, 8'h00);
      chk("done clr", 8'h00, flag(ST_DONE));
    end
    clock_phase_bit = 1'b0;
    acc(0, 8'h40);
    tb_ss_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    acc(2, 8'h11);
    chk("write_collision_flag sel", 8'h01, flag(ST_WRITE_COLLISION_FLAG));
    tb_ss_n = 1'b1;
  endtask : t_slave

  task automatic finish_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (16) @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
    t_reset();
    t_master();
    t_flags();
    t_rates();
    t_mode_fault_flag();
    t_slave();
    finish_test();
  end

  // Run needs about 15 us; cut a hang well beyond that
  initial begin
    #300us;
    miscompares++;
    finish_test();
  end
endmodule : test_spi_master_slave_core
